//--- rtl/dbfc_map.vh
// Register offsets, field positions, reset values and timing counts for the DMA threshold block
`ifndef DBFC_MAP_VH
`define DBFC_MAP_VH

`define DBFC_OFF_THRESH      8'h00
`define DBFC_OFF_TIMER       8'h04
`define DBFC_OFF_CTRL        8'h08
`define DBFC_OFF_STATUS      8'h0c

`define DBFC_RWM_LSB         12
`define DBFC_TSP_LSB         10
`define DBFC_TFW_LSB         8
`define DBFC_RES_ONES        16'hc000

`define DBFC_RWM_RESET       2'h2
`define DBFC_TSP_RESET       2'h2
`define DBFC_TFW_RESET       2'h0
`define DBFC_BURST_RESET     8'h10

`define DBFC_CTRL_STOP       0
`define DBFC_CTRL_TIMER_EN   1
`define DBFC_CTRL_BLD        2
`define DBFC_CTRL_TEST       3
`define DBFC_CTRL_RUNT       4

`define DBFC_RUNT_BYTES      8'd64
`define DBFC_RETAIN_BYTES    8'd64
`define DBFC_TICK_NS         100
`define DBFC_CLK_NS          8
`define DBFC_TICK_CYCLES     (`DBFC_TICK_NS / `DBFC_CLK_NS)

`define DBFC_RESP_OKAY       2'h0
`define DBFC_RESP_SLVERR     2'h2

`endif

//--- rtl/dbfc_ctrl.v
// DMA burst, FIFO threshold and bus hold timer control with AXI4-Lite registers
//
// Functional notes
// - Receive DMA requested once receive FIFO reaches 16, 32 or 64 bytes.
// - Without runt accept, a new frame needs 64 bytes received before any receive DMA starts.
// - Runt accept: request at watermark or on a complete valid frame.
// - Receive watermark resets to 10b, the 64-byte threshold.
// - Preamble starts when frame bytes in transmit FIFO reach 4/16/64/112.
// - A whole frame in the transmit FIFO starts transmission regardless.
// - Transmit start point resets to 10b, 64 bytes.
// - Transmit data kept until 64 bytes or whole short frame sent.
// - Transmit DMA only while FIFO has room for 8/16/32 writes.
// - Transmit FIFO watermark resets to 00b, eight write cycles.
// - Burst count caps FIFO data transfers per DMA cycle, not descriptors.
// - Burst count of zero allows exactly one transfer.
// - Burst count loads 16 on reset.
// - Burst limit disable bit makes burst count ignored.
// - Timer enabled: release bus on time expiry or transfer count, first.
// - Test enable: writes to burst count or timer also decrement once.
// - Bus timer active only when enabled; software loads it first.
// - Hold time measured from DMA acknowledge; FIFO data only.
// - Timer value zero allows a single bus cycle per mastership.
// - Nonzero timer value counts 100 ns units.
// - Threshold, burst, timer fields writable only while stopped.
// - Top two threshold bits read as ones; software writes zeros.
`timescale 1ns/1ps
`include "dbfc_map.vh"

module dbfc_ctrl (
    input  wire        core_clk,
    input  wire        rst,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receive FIFO side
    input  wire [7:0]  rx_fifo_bytes,
    input  wire [10:0] rx_frame_bytes,
    input  wire        rx_frame_complete,
    output reg         rx_dma_req,
    // Transmit FIFO side
    input  wire [7:0]  tx_frame_written,
    input  wire        tx_frame_whole,
    input  wire [7:0]  tx_fifo_free,
    input  wire [10:0] tx_frame_sent,
    input  wire        tx_frame_done,
    output reg         tx_start,
    output reg         tx_dma_allow,
    output reg         tx_retain,
    // Bus mastership
    input  wire        dma_ack,
    input  wire        xfer_done,
    input  wire        xfer_is_desc,
    output reg         bus_release
);

    // Register state
    reg [1:0]  receive_watermark;
    reg [1:0]  transmit_start_point;
    reg [1:0]  transmit_fifo_watermark;
    reg [7:0]  burst_count_limit;
    reg [15:0] bus_hold_time_limit;
    reg        ctl_stop;
    reg        ctl_timer_en;
    reg        burst_limit_disable;
    reg        test_enable;
    reg        ctl_runt_accept;

    // Write channel capture
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg        ar_pend;

    // Mastership counters
    reg        master_active;
    reg [7:0]  burst_left;
    reg [15:0] hold_left;
    reg [3:0]  tick_cnt;
    reg        tick_odd;

    wire wr_fire;
    wire rd_fire;
    wire wr_thresh;
    wire wr_timer;
    wire wr_ctrl;
    wire wr_status;
    wire wr_ok;
    wire lo_ok;
    wire hi_ok;
    wire tick;

    // Accept address and data independently; each held until both are present and the write fires with its response
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Address decode of the pending write
    assign wr_thresh = wr_fire && (aw_addr == `DBFC_OFF_THRESH);
    assign wr_timer  = wr_fire && (aw_addr == `DBFC_OFF_TIMER);
    assign wr_ctrl   = wr_fire && (aw_addr == `DBFC_OFF_CTRL);
    assign wr_status = wr_fire && (aw_addr == `DBFC_OFF_STATUS);
    assign wr_ok     = wr_thresh || wr_timer || wr_ctrl || wr_status;
    // Field writes only while stopped; ignored otherwise (still OKAY)
    assign lo_ok = ctl_stop && w_strb[0];
    assign hi_ok = ctl_stop && w_strb[1];

    // Write address and data capture
    always @(posedge core_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DBFC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DBFC_RESP_OKAY : `DBFC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register; stop bit sets on reset so fields are reachable
    always @(posedge core_clk) begin
        if (rst) begin
            ctl_stop            <= 1'b1;
            ctl_timer_en        <= 1'b0;
            burst_limit_disable <= 1'b0;
            test_enable         <= 1'b0;
            ctl_runt_accept     <= 1'b0;
        end else if (wr_ctrl && w_strb[0]) begin
            ctl_stop            <= w_data[`DBFC_CTRL_STOP];
            ctl_timer_en        <= w_data[`DBFC_CTRL_TIMER_EN];
            burst_limit_disable <= w_data[`DBFC_CTRL_BLD];
            test_enable         <= w_data[`DBFC_CTRL_TEST];
            ctl_runt_accept     <= w_data[`DBFC_CTRL_RUNT];
        end
    end

    // Threshold fields and burst count
    always @(posedge core_clk) begin
        if (rst) begin
            receive_watermark       <= `DBFC_RWM_RESET;
            transmit_start_point    <= `DBFC_TSP_RESET;
            transmit_fifo_watermark <= `DBFC_TFW_RESET;
            burst_count_limit       <= `DBFC_BURST_RESET;
        end else if (wr_thresh) begin
            if (hi_ok) begin
                receive_watermark       <= w_data[`DBFC_RWM_LSB+1:`DBFC_RWM_LSB];
                transmit_start_point    <= w_data[`DBFC_TSP_LSB+1:`DBFC_TSP_LSB];
                transmit_fifo_watermark <= w_data[`DBFC_TFW_LSB+1:`DBFC_TFW_LSB];
            end
            // Test mode: the write also performs one decrement
            if (lo_ok) begin
                burst_count_limit <= test_enable ? w_data[7:0] - 8'h01
                                                 : w_data[7:0];
            end
        end
    end

    // Bus hold timer register; undefined in silicon, cleared here for determinism
    always @(posedge core_clk) begin
        if (rst) begin
            bus_hold_time_limit <= 16'h0000;
        end else if (wr_timer && ctl_stop) begin
            if (test_enable) begin
                bus_hold_time_limit <= w_data[15:0] - 16'h0001;
            end else begin
                if (w_strb[0]) begin
                    bus_hold_time_limit[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    bus_hold_time_limit[15:8] <= w_data[15:8];
                end
            end
        end
    end

    // Read channel; unmapped addresses answer SLVERR with zero data
    always @(posedge core_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DBFC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `DBFC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `DBFC_OFF_THRESH: begin
                    // Fields hidden while running; the reserved pair still reads ones
                    if (ctl_stop) begin
                        s_axi_rdata <= {16'h0000, `DBFC_RES_ONES |
                                       {2'b00, receive_watermark, transmit_start_point,
                                        transmit_fifo_watermark, burst_count_limit}};
                    end else begin
                        s_axi_rdata <= {16'h0000, `DBFC_RES_ONES};
                    end
                end
                `DBFC_OFF_TIMER: begin
                    if (ctl_stop) begin
                        s_axi_rdata <= {16'h0000, bus_hold_time_limit};
                    end else begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                end
                `DBFC_OFF_CTRL:
                    s_axi_rdata <= {27'h0000000, ctl_runt_accept, test_enable,
                                    burst_limit_disable, ctl_timer_en, ctl_stop};
                `DBFC_OFF_STATUS:
                    s_axi_rdata <= {24'h000000, burst_left[3:0], master_active,
                                    tx_retain, tx_dma_allow, rx_dma_req};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `DBFC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Receive DMA request decision
    always @(posedge core_clk) begin
        if (rst) begin
            rx_dma_req <= 1'b0;
        end else begin
            case (receive_watermark)
                2'h0: rx_dma_req <= rx_fifo_bytes >= 8'd16;
                2'h1: rx_dma_req <= rx_fifo_bytes >= 8'd32;
                2'h2: rx_dma_req <= rx_fifo_bytes >= 8'd64;
                default: rx_dma_req <= 1'b0; // Reserved code requests only on a complete frame with runt accept
            endcase
            // Runt accept lifts the 64-byte wait; a complete frame goes at any length
            if (rx_frame_complete && ctl_runt_accept) begin
                rx_dma_req <= (rx_fifo_bytes != 8'h00);
            end else if (!ctl_runt_accept &&
                         rx_frame_bytes < {3'b000, `DBFC_RUNT_BYTES}) begin
                rx_dma_req <= 1'b0;
            end
        end
    end

    // Transmit start, DMA permission and retention
    always @(posedge core_clk) begin
        if (rst) begin
            tx_start     <= 1'b0;
            tx_dma_allow <= 1'b0;
            tx_retain    <= 1'b0;
        end else begin
            case (transmit_start_point)
                2'h0: tx_start <= tx_frame_written >= 8'd4;
                2'h1: tx_start <= tx_frame_written >= 8'd16;
                2'h2: tx_start <= tx_frame_written >= 8'd64;
                default: tx_start <= tx_frame_written >= 8'd112;
            endcase
            if (tx_frame_whole) begin
                tx_start <= 1'b1;
            end
            case (transmit_fifo_watermark)
                2'h0: tx_dma_allow <= tx_fifo_free >= 8'd8;
                2'h1: tx_dma_allow <= tx_fifo_free >= 8'd16;
                2'h2: tx_dma_allow <= tx_fifo_free >= 8'd32;
                default: tx_dma_allow <= 1'b0;
            endcase
            // Keep the slot-time window so collision retries need no refill
            tx_retain <= !tx_frame_done &&
                         (tx_frame_sent < {3'b000, `DBFC_RETAIN_BYTES});
        end
    end

    // 100 ns tick restarted at acknowledge; 12 and 13 cycle periods alternate so
    // the 8 ns clock averages exactly 100 ns instead of running 4% fast
    assign tick = tick_odd ? (tick_cnt == `DBFC_TICK_CYCLES)
                           : (tick_cnt == `DBFC_TICK_CYCLES - 1);

    always @(posedge core_clk) begin
        if (rst || !master_active) begin
            tick_cnt <= 4'h0;
            tick_odd <= 1'b0;
        end else if (tick) begin
            tick_cnt <= 4'h0;
            tick_odd <= !tick_odd;
        end else begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    // Mastership period: counts FIFO data transfers and hold time
    always @(posedge core_clk) begin
        if (rst) begin
            master_active <= 1'b0;
            burst_left    <= 8'h00;
            hold_left     <= 16'h0000;
            bus_release   <= 1'b0;
        end else if (!master_active) begin
            bus_release <= 1'b0;
            if (dma_ack) begin
                master_active <= 1'b1;
                // Zero burst count still allows one transfer
                burst_left <= (burst_count_limit == 8'h00) ? 8'h01
                                                           : burst_count_limit;
                hold_left  <= bus_hold_time_limit;
            end
        end else if (!dma_ack) begin
            master_active <= 1'b0;
            bus_release   <= 1'b0;
        end else begin
            // Descriptor transfers are never counted
            if (xfer_done && !xfer_is_desc && burst_left != 8'h00) begin
                burst_left <= burst_left - 8'h01;
            end
            if (tick && hold_left != 16'h0000) begin
                hold_left <= hold_left - 16'h0001;
            end
            // Release on the first limit reached
            if (xfer_done && !xfer_is_desc && !burst_limit_disable &&
                burst_left == 8'h01) begin
                bus_release <= 1'b1;
            end
            if (ctl_timer_en) begin
                if (bus_hold_time_limit == 16'h0000 && xfer_done && !xfer_is_desc) begin
                    bus_release <= 1'b1;
                end
                // An expiry during a descriptor transfer waits, it is never lost
                if (bus_hold_time_limit != 16'h0000 && !(xfer_done && xfer_is_desc) &&
                    ((tick && hold_left == 16'h0001) || hold_left == 16'h0000)) begin
                    bus_release <= 1'b1;
                end
            end
        end
    end

endmodule

//--- verif/dbfc_ctrl_properties.sv
// Port-level assertions for the DMA threshold control block
`timescale 1ns/1ps
module dbfc_ctrl_properties (
    input wire       core_clk,
    input wire       rst,
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire       s_axi_wready,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    input wire [7:0] rx_fifo_bytes,
    input wire       rx_frame_complete,
    input wire       rx_dma_req,
    input wire [7:0] tx_frame_written,
    input wire       tx_frame_whole,
    input wire       tx_start,
    input wire [7:0] tx_fifo_free,
    input wire       tx_dma_allow,
    input wire       dma_ack,
    input wire       bus_release
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Handshake steps of a register access
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    // Threshold floors hold for every code
    a_rx_floor: assert property (rx_fifo_bytes < 16 && !rx_frame_complete |=> !rx_dma_req)
        else $error("receive request below watermark");
    a_tx_point: assert property (tx_frame_written >= 112 |=> tx_start)
        else $error("no start past top start point");
    a_tx_whole: assert property (tx_frame_whole |=> tx_start)
        else $error("whole frame not started");
    a_tx_room: assert property (tx_fifo_free < 8 |=> !tx_dma_allow)
        else $error("transmit DMA without room");
    a_release_hold: assert property (bus_release && dma_ack |=> bus_release)
        else $error("release dropped under grant");
    a_grant_fresh: assert property ($rose(dma_ack) |-> !bus_release)
        else $error("release stale at new grant");
endmodule

bind dbfc_ctrl dbfc_ctrl_properties i_props (.*);

//--- verif/dbfc_isa_host.sv
// Behavioural host bus model: grants mastership and completes transfers
`timescale 1ns/1ps
module dbfc_isa_host (
    input  wire core_clk,
    input  wire bus_release,
    output reg  dma_ack,
    output reg  xfer_done,
    output reg  xfer_is_desc
);
    initial begin
        dma_ack = 1'b0;
        xfer_done = 1'b0;
        xfer_is_desc = 1'b0;
    end

    // Grant, one transfer every gap cycles, descriptors first; gap 2 avoids overrun
    task automatic grant(input int gap, input int desc, input int cap,
                         output int n, output int cy);
        bit p;
        n = 0;
        cy = 0;
        @(posedge core_clk);
        dma_ack <= 1'b1;
        while (bus_release !== 1'b1 && cy < cap) begin
            p = (cy % gap == gap - 1);
            xfer_done <= p;
            // Qualifier toggles when idle so stale values never help
            xfer_is_desc <= p ? (desc > 0) : ~xfer_is_desc;
            if (p && desc > 0) desc--;
            else if (p) n++;
            @(posedge core_clk);
            cy++;
        end
        xfer_done <= 1'b0;
        dma_ack <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

//--- verif/dma_burst_fifo_threshold_ctrl_test.sv
// Self-checking bench for the DMA threshold control block
`timescale 1ns/1ps
`include "dbfc_map.vh"
module dma_burst_fifo_threshold_ctrl_test;
    logic        core_clk, rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  rx_fifo_bytes = 8'h0, tx_frame_written = 8'h0, tx_fifo_free = 8'h0;
    logic [10:0] rx_frame_bytes = 11'h0, tx_frame_sent = 11'h0;
    logic        rx_frame_complete = 1'b0, tx_frame_whole = 1'b0, tx_frame_done = 1'b0;
    logic        rx_dma_req, tx_start, tx_dma_allow, tx_retain;
    logic        dma_ack, xfer_done, xfer_is_desc, bus_release;
    int          error_cnt = 0, num_checks = 0;

    dbfc_ctrl i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .rx_fifo_bytes,
        .rx_frame_bytes, .rx_frame_complete, .rx_dma_req, .tx_frame_written, .tx_frame_whole,
        .tx_fifo_free, .tx_frame_sent, .tx_frame_done, .tx_start, .tx_dma_allow, .tx_retain,
        .dma_ack, .xfer_done, .xfer_is_desc, .bus_release);
    dbfc_isa_host i_host (.core_clk, .bus_release, .dma_ack, .xfer_done, .xfer_is_desc);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic tmo;
        error_cnt++;
        $display("ERROR handshake expected answer seen none");
        summarize();
    endtask

    // Write; bready is held high throughout
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) tmo();
        r = s_axi_bresp;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) tmo();
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Stop, then load fields and timer before the timer is used
    task automatic cfg(input logic [15:0] th, input logic [15:0] tm, input logic [4:0] ct);
        logic [1:0] r;
        axw(`DBFC_OFF_CTRL, {27'h0, ct | 5'h01}, r);
        axw(`DBFC_OFF_THRESH, {16'h0, th}, r);
        axw(`DBFC_OFF_TIMER, {16'h0, tm}, r);
    endtask

    task automatic go(input logic [4:0] ct);
        logic [1:0] r;
        axw(`DBFC_OFF_CTRL, {27'h0, ct}, r);
    endtask

    // One mastership period; a negative expectation skips the count
    task automatic mst(input logic [15:0] th, input logic [15:0] tm, input logic [4:0] ct,
                       input int desc, input int cap, input int en, input int rl,
                       output int cy);
        int n;
        cfg(th, tm, ct);
        go(ct);
        i_host.grant(2, desc, cap, n, cy);
        if (en >= 0) chk("xfers", n, en);
        chk("released", cy < cap, rl);
    endtask

    // Reference model of the three threshold flags
    function automatic logic [2:0] dp_exp(int c, int rn, int f, int b, int cp,
                                          int w, int wh, int fr);
        int wm[4] = '{16, 32, 64, 999};
        int sp[4] = '{4, 16, 64, 112};
        int fw[4] = '{8, 16, 32, 999};
        bit rx;
        rx = rn ? (f >= wm[c] || (cp && f > 0)) : (f >= wm[c] && b >= 64);
        return {rx, w >= sp[c] || wh, fr >= fw[c]};
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n, cy, f, b, cp, w, wh, fr, i, ts, td;
        logic [2:0]  c, k;
        void'($urandom(32'h540e5c05));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        axr(`DBFC_OFF_THRESH, d, r);
        chk("thresh", d, 32'h0000e810);
        axr(`DBFC_OFF_TIMER, d, r);
        chk("timer", d, 32'h0);
        axr(`DBFC_OFF_CTRL, d, r);
        chk("ctrl", d, 32'h1);
        axr(8'h10, d, r);
        chk("unmapped_rd", r, `DBFC_RESP_SLVERR);
        axw(8'h10, 32'h0, r);
        chk("unmapped_wr", r, `DBFC_RESP_SLVERR);
        go(5'h00);
        i_host.grant(2, 0, 100, n, cy);
        chk("reset_burst", n, 16);
        $display("test reset done");
        // Every code of the three thresholds, runt accept off then on
        for (k = 0; k < 2; k++) for (c = 0; c < 4; c++) begin
            cfg({2'b00, c[1:0], c[1:0], c[1:0], 8'h10}, 16'h0, {k[0], 4'h0});
            go({k[0], 4'h0});
            for (i = 0; i < 25; i++) begin
                f = $urandom % 129;
                b = $urandom % 200;
                cp = k[0] && c < 3 && ($urandom % 2);
                w = $urandom % 130;
                wh = ($urandom % 4) == 0;
                fr = $urandom % 40;
                rx_fifo_bytes <= 8'(f);
                rx_frame_bytes <= 11'(b);
                rx_frame_complete <= cp[0];
                tx_frame_written <= 8'(w);
                tx_frame_whole <= wh[0];
                tx_fifo_free <= 8'(fr);
                ts = $urandom % 128;
                td = $urandom % 2;
                tx_frame_sent <= 11'(ts);
                tx_frame_done <= td[0];
                repeat (2) @(posedge core_clk);
                chk("flags", {rx_dma_req, tx_start, tx_dma_allow},
                    dp_exp(c, k, f, b, cp, w, wh, fr));
                chk("retain", tx_retain, td == 0 && ts < 64);
            end
        end
        axr(`DBFC_OFF_THRESH, d, r);
        chk("thresh_hidden", d, 32'h0000c000);
        axw(`DBFC_OFF_THRESH, 32'h0, r);
        axw(`DBFC_OFF_CTRL, 32'h1, r);
        axr(`DBFC_OFF_THRESH, d, r);
        chk("thresh_locked", d, 32'h0000ff10);
        cfg(16'h2805, 16'h0005, 5'h08);
        axr(`DBFC_OFF_THRESH, d, r);
        chk("burst_dec", d, 32'h0000e804);
        axr(`DBFC_OFF_TIMER, d, r);
        chk("timer_dec", d, 32'h4);
        $display("test thresholds done");
        mst(16'h2803, 16'h0, 5'h00, 2, 100, 3, 1, cy);
        mst(16'h2800, 16'h0, 5'h00, 0, 100, 1, 1, cy);
        mst(16'h2803, 16'h0, 5'h04, 0, 60, 30, 0, cy);
        mst(16'h2810, 16'h0, 5'h02, 0, 100, 1, 1, cy);
        mst(16'h2814, 16'h1, 5'h00, 0, 100, 20, 1, cy);
        mst(16'h2805, 16'd200, 5'h02, 0, 3000, 5, 1, cy);
        mst(16'h28ff, 16'h4, 5'h02, 0, 200, -1, 1, cy);
        chk("hold_time", cy >= 44 && cy <= 54, 1'b1);
        $display("test mastership done");
        summarize();
    end
endmodule
